// file: hdl/ulep_defs.vh
`ifndef ULEP_DEFS_VH
`define ULEP_DEFS_VH
// ---------------------------------------------------------------
// register byte addresses on the apb word map
// ---------------------------------------------------------------
`define ULEP_ADDR_IRQ0 12'h000
`define ULEP_ADDR_IRQ1 12'h004
`define ULEP_ADDR_CFG0 12'h008
`define ULEP_ADDR_CFG1 12'h00c
`define ULEP_ADDR_CFG2 12'h010
`define ULEP_ADDR_STAT 12'h014
// ---------------------------------------------------------------
// interrupt status 0 fields
// ---------------------------------------------------------------
`define ULEP_I0_TXF 7
`define ULEP_I0_RXF 6
`define ULEP_I0_SUSP 4
`define ULEP_I0_TXIE 3
`define ULEP_I0_RXIE 2
`define ULEP_I0_TXCLR 1
`define ULEP_I0_RXCLR 0
// ---------------------------------------------------------------
// interrupt status 1 fields
// ---------------------------------------------------------------
`define ULEP_I1_TXF 7
`define ULEP_I1_END_OF_PACKET_FLAG 6
`define ULEP_I1_WKF 5
`define ULEP_I1_WKCLR 4
`define ULEP_I1_TXIE 3
`define ULEP_I1_END_OF_PACKET_IRQ_ENABLE 2
`define ULEP_I1_TXCLR 1
`define ULEP_I1_EOPCLR 0
// ---------------------------------------------------------------
// config 0 and 1 fields (length is bits 3..0)
// ---------------------------------------------------------------
`define ULEP_C0_TOG 7
`define ULEP_C0_STALL 6
`define ULEP_C0_TXARM 5
`define ULEP_C0_RXARM 4
`define ULEP_C1_TOG 7
`define ULEP_C1_TGT 6
`define ULEP_C1_TXARM 5
`define ULEP_C1_WAKE 4
// ---------------------------------------------------------------
// config 2 fields
// ---------------------------------------------------------------
`define ULEP_C2_IBOCLR 6
`define ULEP_C2_IBOF 5
`define ULEP_C2_EP2EN 3
`define ULEP_C2_EP1EN 2
`define ULEP_C2_EP2STALL 1
`define ULEP_C2_EP1STALL 0
// ---------------------------------------------------------------
// token and handshake codes
// ---------------------------------------------------------------
`define ULEP_TOK_IN 2'h0
`define ULEP_TOK_OUT 2'h1
`define ULEP_TOK_SETUP 2'h2
`define ULEP_HS_NONE 2'h0
`define ULEP_HS_DATA 2'h1
`define ULEP_HS_NAK 2'h2
`define ULEP_HS_STALL 2'h3
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ULEP_WAKE_MIN_MS 10
`define ULEP_WAKE_MAX_MS 15
`define ULEP_IDLE_SUSP_MS 3
`endif

// file: hdl/ulep_endpoint_ctrl.v
// Notes on behaviour
// - ep0 tx flag with enable raises interrupt
// - ep0 rx flag with enable raises interrupt
// - writing one clears ep0 tx/rx flags
// - ep1/2 flag set after acked transmit
// - end-of-packet flag set on detected eop
// - wake flag set on activity while suspended
// - write one clears wake, eop, ep12 flags
// - ep12 flag with enable raises interrupt
// - eop flag with enable raises interrupt
// - ep0 toggle picks data pid, software only
// - ep0 stall answers in/out; setup clears
// - ep0 in nak when unarmed or flagged
// - ep0 out nak when unarmed or flagged
// - four-bit ep0 transmit length, reset zero
// - ep12 toggle picks data pid, software only
// - buffer target selects ep2 or ep1
// - ep1/2 in nak when unarmed or flagged
// - wake drive forces k, no wake flag
// - four-bit ep12 transmit length, reset zero
// - rx flag set while tx set marks order
// - writing one clears in-before-out flag
// - suspend bit drives usb_clk_stop, module clock keeps running
// - all sources share one interrupt line
// - wake flag interrupts without enable
`timescale 1ns/1ns
`include "ulep_defs.vh"
module ulep_endpoint_ctrl
(
  input wire pclk,
  input wire presetn,
  input wire pclk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // token side from the serial engine
  input wire tok_valid,
  input wire [1:0] tok_pid,
  input wire [1:0] tok_ep,
  input wire rx_data_ok,
  input wire rx_data_pid1,
  input wire [3:0] rx_count,
  input wire tx_acked,
  input wire eop_seen,
  input wire bus_activity,
  // answers to the serial engine
  output reg [1:0] hs_code,
  output reg hs_valid,
  output reg hs_data_pid1,
  output reg [3:0] hs_length,
  output reg hs_from_shared,
  output reg drive_k,
  output reg usb_clk_stop,
  output reg irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg ep0_tx_done_flag_q;
  reg ep0_rx_done_flag_q;
  reg ep0_tx_irq_enable_q;
  reg ep0_rx_irq_enable_q;
  reg low_power_request_q;
  reg ep12_tx_done_flag_q;
  reg end_of_packet_flag_q;
  reg wakeup_seen_flag_q;
  reg ep12_tx_irq_enable_q;
  reg end_of_packet_irq_enable_q;
  reg ep0_tx_toggle_q;
  reg ep0_force_stall_q;
  reg ep0_tx_arm_q;
  reg ep0_rx_arm_q;
  reg [3:0] ep0_tx_length_q;
  reg ep12_tx_toggle_q;
  reg shared_buffer_target_q;
  reg ep12_tx_arm_q;
  reg remote_wakeup_drive_q;
  reg [3:0] ep12_tx_length_q;
  reg in_before_out_flag_q;
  reg ep1_active_q;
  reg ep2_active_q;
  reg ep1_force_stall_q;
  reg ep2_force_stall_q;
  reg rx_pid1_q;
  reg setup_seen_q;
  reg [3:0] rx_count_q;
  // pending transaction: 0 none, 1 ep0 in, 2 ep0 out/setup, 3 ep12 in
  reg [1:0] pend_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;

  // one function decodes an address hit, used for every register
  function hit;
    input [11:0] a;
    input [11:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  wire known = hit(paddr, `ULEP_ADDR_IRQ0) | hit(paddr, `ULEP_ADDR_IRQ1) |
               hit(paddr, `ULEP_ADDR_CFG0) | hit(paddr, `ULEP_ADDR_CFG1) |
               hit(paddr, `ULEP_ADDR_CFG2) | hit(paddr, `ULEP_ADDR_STAT);
  wire w0 = wr_acc & hit(paddr, `ULEP_ADDR_IRQ0);
  wire w1 = wr_acc & hit(paddr, `ULEP_ADDR_IRQ1);
  wire wc0 = wr_acc & hit(paddr, `ULEP_ADDR_CFG0);
  wire wc1 = wr_acc & hit(paddr, `ULEP_ADDR_CFG1);
  wire wc2 = wr_acc & hit(paddr, `ULEP_ADDR_CFG2);

  // ---------------------------------------------------------------
  // token classification
  // ---------------------------------------------------------------
  wire is_in = tok_valid & (tok_pid == `ULEP_TOK_IN);
  wire is_out = tok_valid & (tok_pid == `ULEP_TOK_OUT);
  wire is_setup = tok_valid & (tok_pid == `ULEP_TOK_SETUP);
  wire ep0 = (tok_ep == 2'h0);
  wire ep1 = (tok_ep == 2'h1);
  wire ep2 = (tok_ep == 2'h2);
  // a set flag or clear arm blocks the transfer
  wire ep0_in_blk = ~ep0_tx_arm_q | ep0_tx_done_flag_q;
  wire ep0_out_blk = ~ep0_rx_arm_q | ep0_rx_done_flag_q;
  wire ep12_blk = ~ep12_tx_arm_q | ep12_tx_done_flag_q;
  // shared buffer must point at the polled endpoint
  wire tgt_bad = ep2 ? ~shared_buffer_target_q : shared_buffer_target_q;
  wire ep_stall = ep1 ? ep1_force_stall_q : ep2_force_stall_q;
  wire ep_act = ep1 ? ep1_active_q : ep2_active_q;

  // ---------------------------------------------------------------
  // handshake decision, stall before nak before data
  // ---------------------------------------------------------------
  reg [1:0] hs_d;
  reg [1:0] pend_d;
  always @*
  begin
    hs_d = `ULEP_HS_NONE;
    pend_d = 2'h0;
    if (is_setup & ep0)
    begin
      // setup is never stalled or refused
      hs_d = `ULEP_HS_DATA;
      pend_d = 2'h2;
    end
    else if ((is_in | is_out) & ep0)
    begin
      if (ep0_force_stall_q)
        hs_d = `ULEP_HS_STALL;
      else if (is_in ? ep0_in_blk : ep0_out_blk)
        hs_d = `ULEP_HS_NAK;
      else
      begin
        hs_d = `ULEP_HS_DATA;
        pend_d = is_in ? 2'h1 : 2'h2;
      end
    end
    else if ((is_in | is_out) & (ep1 | ep2))
    begin
      if (!ep_act)
        hs_d = `ULEP_HS_NONE; // disabled endpoint stays silent
      else if (ep_stall)
        hs_d = `ULEP_HS_STALL;
      else if (is_out | ep12_blk | tgt_bad)
        hs_d = `ULEP_HS_NAK;
      else
      begin
        hs_d = `ULEP_HS_DATA;
        pend_d = 2'h3;
      end
    end
  end

  // ---------------------------------------------------------------
  // flag events
  // ---------------------------------------------------------------
  wire ev_tx0 = tx_acked & (pend_q == 2'h1); // ep0 in acked
  wire ev_rx0 = rx_data_ok & (pend_q == 2'h2); // ep0 data acked
  wire ev_tx12 = tx_acked & (pend_q == 2'h3);
  // wake drive itself must not set the wake flag
  wire ev_wk = bus_activity & low_power_request_q & ~remote_wakeup_drive_q;

  // ---------------------------------------------------------------
  // registers: set wins over clear on every flag
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ep0_tx_done_flag_q <= 1'b0;
      ep0_rx_done_flag_q <= 1'b0;
      ep0_tx_irq_enable_q <= 1'b0;
      ep0_rx_irq_enable_q <= 1'b0;
      low_power_request_q <= 1'b0;
      ep12_tx_done_flag_q <= 1'b0;
      end_of_packet_flag_q <= 1'b0;
      wakeup_seen_flag_q <= 1'b0;
      ep12_tx_irq_enable_q <= 1'b0;
      end_of_packet_irq_enable_q <= 1'b0;
      ep0_tx_toggle_q <= 1'b0;
      ep0_force_stall_q <= 1'b0;
      ep0_tx_arm_q <= 1'b0;
      ep0_rx_arm_q <= 1'b0;
      ep0_tx_length_q <= 4'h0;
      ep12_tx_toggle_q <= 1'b0;
      shared_buffer_target_q <= 1'b0;
      ep12_tx_arm_q <= 1'b0;
      remote_wakeup_drive_q <= 1'b0;
      ep12_tx_length_q <= 4'h0;
      in_before_out_flag_q <= 1'b0;
      ep1_active_q <= 1'b0;
      ep2_active_q <= 1'b0;
      ep1_force_stall_q <= 1'b0;
      ep2_force_stall_q <= 1'b0;
      rx_pid1_q <= 1'b0;
      setup_seen_q <= 1'b0;
      rx_count_q <= 4'h0;
      pend_q <= 2'h0;
    end
    else if (pclk_en)
    begin
      // interrupt status 0: enables and suspend request
      if (w0)
      begin
        ep0_tx_irq_enable_q <= pwdata[`ULEP_I0_TXIE];
        ep0_rx_irq_enable_q <= pwdata[`ULEP_I0_RXIE];
        low_power_request_q <= pwdata[`ULEP_I0_SUSP];
      end
      // ep0 tx flag
      if (ev_tx0)
        ep0_tx_done_flag_q <= 1'b1;
      else if (w0 & pwdata[`ULEP_I0_TXCLR])
        ep0_tx_done_flag_q <= 1'b0;
      // ep0 rx flag
      if (ev_rx0)
        ep0_rx_done_flag_q <= 1'b1;
      else if (w0 & pwdata[`ULEP_I0_RXCLR])
        ep0_rx_done_flag_q <= 1'b0;
      // interrupt status 1 enables
      if (w1)
      begin
        ep12_tx_irq_enable_q <= pwdata[`ULEP_I1_TXIE];
        end_of_packet_irq_enable_q <= pwdata[`ULEP_I1_END_OF_PACKET_IRQ_ENABLE];
      end
      if (ev_tx12)
        ep12_tx_done_flag_q <= 1'b1;
      else if (w1 & pwdata[`ULEP_I1_TXCLR])
        ep12_tx_done_flag_q <= 1'b0;
      if (eop_seen)
        end_of_packet_flag_q <= 1'b1;
      else if (w1 & pwdata[`ULEP_I1_EOPCLR])
        end_of_packet_flag_q <= 1'b0;
      if (ev_wk)
        wakeup_seen_flag_q <= 1'b1;
      else if (w1 & pwdata[`ULEP_I1_WKCLR])
        wakeup_seen_flag_q <= 1'b0;
      // control endpoint config
      if (wc0)
      begin
        ep0_tx_toggle_q <= pwdata[`ULEP_C0_TOG];
        ep0_tx_arm_q <= pwdata[`ULEP_C0_TXARM];
        ep0_rx_arm_q <= pwdata[`ULEP_C0_RXARM];
        ep0_tx_length_q <= pwdata[3:0];
      end
      // setup clears stall and wins over a same-cycle write
      if (is_setup & ep0)
        ep0_force_stall_q <= 1'b0;
      else if (wc0)
        ep0_force_stall_q <= pwdata[`ULEP_C0_STALL];
      // interrupt endpoint config
      if (wc1)
      begin
        ep12_tx_toggle_q <= pwdata[`ULEP_C1_TOG];
        shared_buffer_target_q <= pwdata[`ULEP_C1_TGT];
        ep12_tx_arm_q <= pwdata[`ULEP_C1_TXARM];
        remote_wakeup_drive_q <= pwdata[`ULEP_C1_WAKE];
        ep12_tx_length_q <= pwdata[3:0];
      end
      // endpoint enable and order register
      if (wc2)
      begin
        ep2_active_q <= pwdata[`ULEP_C2_EP2EN];
        ep1_active_q <= pwdata[`ULEP_C2_EP1EN];
        ep2_force_stall_q <= pwdata[`ULEP_C2_EP2STALL];
        ep1_force_stall_q <= pwdata[`ULEP_C2_EP1STALL];
      end
      if (ev_rx0 & ep0_tx_done_flag_q)
        in_before_out_flag_q <= 1'b1;
      else if (wc2 & pwdata[`ULEP_C2_IBOCLR])
        in_before_out_flag_q <= 1'b0;
      // receive status capture
      if (ev_rx0)
      begin
        rx_pid1_q <= rx_data_pid1;
        rx_count_q <= rx_count;
      end
      if (tok_valid & ep0)
        setup_seen_q <= is_setup;
      // track the open transaction
      if (tok_valid)
        pend_q <= pend_d;
      else if (tx_acked | rx_data_ok)
        pend_q <= 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all registered
  // ---------------------------------------------------------------
  wire irq_d = (ep0_tx_done_flag_q & ep0_tx_irq_enable_q) |
               (ep0_rx_done_flag_q & ep0_rx_irq_enable_q) |
               (ep12_tx_done_flag_q & ep12_tx_irq_enable_q) |
               (end_of_packet_flag_q & end_of_packet_irq_enable_q) |
               wakeup_seen_flag_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hs_code <= `ULEP_HS_NONE;
      hs_valid <= 1'b0;
      hs_data_pid1 <= 1'b0;
      hs_length <= 4'h0;
      hs_from_shared <= 1'b0;
      drive_k <= 1'b0;
      usb_clk_stop <= 1'b0;
      irq <= 1'b0;
    end
    else if (pclk_en)
    begin
      hs_valid <= tok_valid;
      hs_code <= hs_d;
      hs_from_shared <= (pend_d == 2'h3);
      // data pid and length from the ep0 or ep12 toggle and length
      hs_data_pid1 <= ep0 ? ep0_tx_toggle_q : ep12_tx_toggle_q;
      hs_length <= ep0 ? ep0_tx_length_q : ep12_tx_length_q;
      drive_k <= remote_wakeup_drive_q;
      usb_clk_stop <= low_power_request_q;
      irq <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // apb read data and ready, one wait-free cycle
  // ---------------------------------------------------------------
  reg [7:0] rd_d;
  always @*
  begin
    rd_d = 8'h00;
    if (hit(paddr, `ULEP_ADDR_IRQ0))
      rd_d = {ep0_tx_done_flag_q, ep0_rx_done_flag_q, 1'b0,
              low_power_request_q, ep0_tx_irq_enable_q,
              ep0_rx_irq_enable_q, 2'b00};
    else if (hit(paddr, `ULEP_ADDR_IRQ1))
      rd_d = {ep12_tx_done_flag_q, end_of_packet_flag_q,
              wakeup_seen_flag_q, 1'b0, ep12_tx_irq_enable_q,
              end_of_packet_irq_enable_q, 2'b00};
    else if (hit(paddr, `ULEP_ADDR_CFG0))
      rd_d = {ep0_tx_toggle_q, ep0_force_stall_q, ep0_tx_arm_q,
              ep0_rx_arm_q, ep0_tx_length_q};
    else if (hit(paddr, `ULEP_ADDR_CFG1))
      rd_d = {ep12_tx_toggle_q, shared_buffer_target_q, ep12_tx_arm_q,
              remote_wakeup_drive_q, ep12_tx_length_q};
    else if (hit(paddr, `ULEP_ADDR_CFG2))
      rd_d = {2'b00, in_before_out_flag_q, 1'b0, ep2_active_q,
              ep1_active_q, ep2_force_stall_q, ep1_force_stall_q};
    else if (hit(paddr, `ULEP_ADDR_STAT))
      rd_d = {rx_pid1_q, setup_seen_q, 2'b00, rx_count_q};
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (pclk_en)
    begin
      // ready answers in the cycle after setup, then drops
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      if (psel & ~penable & ~pwrite)
        prdata <= {24'h000000, rd_d};
    end
  end
endmodule

// file: verif/ulep_checker.sv
`timescale 1ns/1ns
`include "ulep_defs.vh"
// ----------------------------------------
// port-level checks of the endpoint block
// ----------------------------------------
module ulep_checker
(
  input wire pclk,
  input wire presetn,
  input wire pclk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire tok_valid,
  input wire [1:0] tok_pid,
  input wire [1:0] tok_ep,
  input wire bus_activity,
  input wire hs_valid,
  input wire [1:0] hs_code,
  input wire drive_k,
  input wire usb_clk_stop,
  input wire irq
);
  // one domain, one reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_wait;
    psel && !penable |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("pready missing in access cycle");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held too long");
  property p_unmapped;
    psel && !penable && paddr > 12'h014 |=> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_upper_zero;
    pready && !pwrite |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper bits not zero");
  property p_hs_next;
    tok_valid && pclk_en |=> hs_valid;
  endproperty
  a_hs_next: assert property (p_hs_next)
    else $error("no handshake after token");
  property p_hs_quiet;
    !tok_valid |=> !hs_valid;
  endproperty
  a_hs_quiet: assert property (p_hs_quiet)
    else $error("handshake without token");
  property p_setup_data;
    tok_valid && pclk_en && tok_pid == `ULEP_TOK_SETUP && tok_ep == 2'h0
      |=> hs_code == `ULEP_HS_DATA;
  endproperty
  a_setup_data: assert property (p_setup_data)
    else $error("setup not accepted");
  property p_wake_irq;
    bus_activity && usb_clk_stop && !drive_k && pclk_en |-> ##2 irq;
  endproperty
  a_wake_irq: assert property (p_wake_irq)
    else $error("wake activity gave no interrupt");
endmodule
bind ulep_endpoint_ctrl ulep_checker u_ulep_checker (.pclk(pclk),
  .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tok_valid(tok_valid), .tok_pid(tok_pid),
  .tok_ep(tok_ep), .bus_activity(bus_activity), .hs_valid(hs_valid),
  .hs_code(hs_code), .drive_k(drive_k), .usb_clk_stop(usb_clk_stop),
  .irq(irq));

// file: verif/ulep_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// host controller and serial engine stand-in
// ----------------------------------------
module ulep_host_model
(
  input wire pclk,
  output reg tok_valid,
  output reg [1:0] tok_pid,
  output reg [1:0] tok_ep,
  output reg rx_data_ok,
  output reg rx_data_pid1,
  output reg [3:0] rx_count,
  output reg tx_acked,
  output reg eop_seen,
  output reg bus_activity
);
  // all lines quiet at time zero
  initial
  begin
    {tok_valid, tok_pid, tok_ep, rx_data_ok, rx_data_pid1} = 6'h0;
    {rx_count, tx_acked, eop_seen, bus_activity} = 7'h0;
  end
  // one token for one cycle; idle fields flip so stale values show
  task token(input [1:0] p, input [1:0] e);
    tok_valid <= 1'b1;
    tok_pid <= p;
    tok_ep <= e;
    @(posedge pclk);
    tok_valid <= 1'b0;
    tok_pid <= ~p;
    tok_ep <= ~e;
    @(posedge pclk);
  endtask
  // receive status that goes with the next rx ok pulse
  task rxval(input p, input [3:0] n);
    rx_data_pid1 <= p;
    rx_count <= n;
  endtask
  // event pulse: bit0 ack, bit1 rx ok, bit2 eop, bit3 bus activity
  // receive status flips after the pulse so stale values show
  task evt(input [3:0] m);
    {bus_activity, eop_seen, rx_data_ok, tx_acked} <= m;
    @(posedge pclk);
    {bus_activity, eop_seen, rx_data_ok, tx_acked} <= 4'h0;
    rx_data_pid1 <= ~rx_data_pid1;
    rx_count <= ~rx_count;
    @(posedge pclk);
  endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/1ns
`include "ulep_defs.vh"
module tb;
  localparam [1:0] HD = `ULEP_HS_DATA;
  localparam [1:0] HN = `ULEP_HS_NAK;
  localparam [1:0] HS = `ULEP_HS_STALL;
  localparam [1:0] TI = `ULEP_TOK_IN;
  localparam [1:0] TO = `ULEP_TOK_OUT;
  reg pclk = 0, presetn = 0, pclk_en = 1, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, r = 32'h6c9d3084;
  wire [31:0] prdata;
  wire pready, pslverr, tok_valid, rx_data_ok, rx_data_pid1, tx_acked;
  wire eop_seen, bus_activity, hs_valid, hs_data_pid1, hs_from_shared;
  wire drive_k, usb_clk_stop, irq;
  wire [1:0] tok_pid, tok_ep, hs_code;
  wire [3:0] rx_count, hs_length;
  integer error_cnt = 0, checked = 0, cyc = 0, t;
  reg [7:0] q_rd[$];
  reg [8:0] q_hs[$];
  reg [8:0] e;
  ulep_endpoint_ctrl u_ulep_endpoint_ctrl (.pclk(pclk), .presetn(presetn),
    .pclk_en(pclk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tok_valid(tok_valid), .tok_pid(tok_pid),
    .tok_ep(tok_ep), .rx_data_ok(rx_data_ok), .rx_data_pid1(rx_data_pid1),
    .rx_count(rx_count), .tx_acked(tx_acked), .eop_seen(eop_seen),
    .bus_activity(bus_activity), .hs_code(hs_code), .hs_valid(hs_valid),
    .hs_data_pid1(hs_data_pid1), .hs_length(hs_length),
    .hs_from_shared(hs_from_shared), .drive_k(drive_k),
    .usb_clk_stop(usb_clk_stop), .irq(irq));
  ulep_host_model u_ulep_host_model (.pclk(pclk), .tok_valid(tok_valid),
    .tok_pid(tok_pid), .tok_ep(tok_ep), .rx_data_ok(rx_data_ok),
    .rx_data_pid1(rx_data_pid1), .rx_count(rx_count), .tx_acked(tx_acked),
    .eop_seen(eop_seen), .bus_activity(bus_activity));
  // 100 MHz clock
  initial
  begin
    forever #5 pclk = ~pclk;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected handshake: full compare flag, code, pid, length, shared
  function [8:0] hx(input [1:0] c, input p, input [3:0] l, input s, f);
    hx = {f, c, p, l, s};
  endfunction
  task check(input string nm, input [7:0] seen, input [7:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // apb transfer; a read notes its expected byte
  task apb(input wr, input [11:0] a, input [7:0] d);
    if (!wr)
      q_rd.push_back(d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task tok(input [1:0] p, input [1:0] ep, input [8:0] x);
    q_hs.push_back(x);
    u_ulep_host_model.token(p, ep);
  endtask
  task irqchk(input v);
    repeat (3) @(posedge pclk);
    check("irq", {7'h0, irq}, {7'h0, v});
  endtask
  // monitor: oldest note against each result
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("prdata", prdata[7:0], q_rd.pop_front());
    // addresses past the last register are refused; every other address used here is mapped
    if (psel && penable && pready === 1'b1)
      check("pslverr", {7'h0, pslverr}, {7'h0, paddr > `ULEP_ADDR_STAT});
    if (hs_valid === 1'b1)
    begin
      e = q_hs.pop_front();
      check("hs", e[8] ? {hs_code, hs_data_pid1, hs_length, hs_from_shared}
        : {hs_code, 6'h0}, e[7:0]);
    end
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and one unmapped read
    for (t = 0; t < 7; t = t + 1)
      if (t != 5)
        apb(0, t * 4, 8'h00);
    $display("test reset done");
    tok(TI, 0, hx(HN, 0, 0, 0, 0));
    r = lfsr(r);
    apb(1, 12'h008, {4'ha, r[3:0]});
    apb(1, 12'h000, 8'h08);
    tok(TI, 0, hx(HD, 1, r[3:0], 0, 1));
    u_ulep_host_model.evt(4'h1);
    irqchk(1);
    apb(0, 12'h000, 8'h88);
    tok(TI, 0, hx(HN, 0, 0, 0, 0));
    apb(1, 12'h000, 8'h08);
    apb(0, 12'h000, 8'h88);
    apb(1, 12'h000, 8'h0a);
    apb(0, 12'h000, 8'h08);
    irqchk(0);
    apb(0, 12'h008, {4'ha, r[3:0]});
    $display("test ep0 in done");
    apb(1, 12'h008, 8'h70);
    tok(TI, 0, hx(HS, 0, 0, 0, 0));
    tok(TO, 0, hx(HS, 0, 0, 0, 0));
    tok(`ULEP_TOK_SETUP, 0, hx(HD, 0, 0, 0, 0));
    apb(0, 12'h008, 8'h30);
    apb(0, 12'h014, 8'h40);
    apb(1, 12'h000, 8'h04);
    tok(TI, 0, hx(HD, 0, 0, 0, 1));
    u_ulep_host_model.evt(4'h1);
    irqchk(0);
    tok(TO, 0, hx(HD, 0, 0, 0, 0));
    r = lfsr(r);
    u_ulep_host_model.rxval(r[4], r[3:0]);
    u_ulep_host_model.evt(4'h2);
    irqchk(1);
    apb(0, 12'h000, 8'hc4);
    apb(0, 12'h010, 8'h20);
    apb(0, 12'h014, {r[4], 3'b000, r[3:0]});
    tok(TO, 0, hx(HN, 0, 0, 0, 0));
    tok(TI, 0, hx(HN, 0, 0, 0, 0));
    apb(1, 12'h010, 8'h40);
    apb(0, 12'h010, 8'h00);
    apb(1, 12'h000, 8'h03);
    apb(0, 12'h000, 8'h00);
    $display("test ep0 stall and out done");
    apb(1, 12'h010, 8'h0c);
    for (t = 0; t < 2; t = t + 1)
    begin
      r = lfsr(r);
      apb(1, 12'h00c, {t[0], t[0], 2'b10, r[3:0]});
      if (t == 0)
        tok(TI, 1, hx(HD, 0, r[3:0], 1, 1));
      tok(TI, 2, t ? hx(HD, 1, r[3:0], 1, 1) : hx(HN, 0, 0, 0, 0));
    end
    apb(1, 12'h004, 8'h08);
    u_ulep_host_model.evt(4'h1);
    irqchk(1);
    apb(0, 12'h004, 8'h88);
    tok(TI, 2, hx(HN, 0, 0, 0, 0));
    apb(1, 12'h004, 8'h0a);
    apb(0, 12'h004, 8'h08);
    apb(1, 12'h010, 8'h0e);
    tok(TI, 2, hx(HS, 0, 0, 0, 0));
    $display("test shared endpoint done");
    apb(1, 12'h004, 8'h04);
    u_ulep_host_model.evt(4'h4);
    irqchk(1);
    apb(0, 12'h004, 8'h44);
    apb(1, 12'h004, 8'h05);
    apb(0, 12'h004, 8'h04);
    apb(1, 12'h004, 8'h00);
    apb(1, 12'h000, 8'h10);
    @(posedge pclk);
    check("clk_stop", {7'h0, usb_clk_stop}, 8'h01);
    u_ulep_host_model.evt(4'h8);
    irqchk(1);
    apb(0, 12'h004, 8'h20);
    apb(1, 12'h004, 8'h10);
    apb(0, 12'h004, 8'h00);
    apb(1, 12'h00c, 8'h10);
    @(posedge pclk);
    check("drive_k", {7'h0, drive_k}, 8'h01);
    u_ulep_host_model.evt(4'h8);
    apb(0, 12'h004, 8'h00);
    apb(1, 12'h00c, 8'h00);
    apb(1, 12'h000, 8'h00);
    // an eop while the clock enable is low must leave the flag alone
    pclk_en <= 1'b0;
    u_ulep_host_model.evt(4'h4);
    pclk_en <= 1'b1;
    apb(0, 12'h004, 8'h00);
    $display("test eop and wake done");
    report_and_stop;
  end
endmodule
